/* common/aepo_regs.vh */
// Constants for the angle encoder serial port and pulse output
`ifndef AEPO_REGS_VH
`define AEPO_REGS_VH

// Frame layout
`define AEPO_CMD_BITS       5
`define AEPO_DATA_BITS      16
`define AEPO_FRAME_BITS     21

// Command codes
`define AEPO_CMD_RD_ANGLE   5'h00
`define AEPO_CMD_RD_MULTI   5'h01
`define AEPO_CMD_RD_BOTH    5'h04
`define AEPO_CMD_RD_CUSTOM  5'h07
`define AEPO_CMD_WR_CONFIG  5'h11
`define AEPO_CMD_WR_CUSTOM  5'h17
`define AEPO_CMD_XT_FIRST   5'h18

// Custom and config word field positions
`define AEPO_WLSB_MSB       13
`define AEPO_WLSB_LSB       7
`define AEPO_GAIN_MSB       6
`define AEPO_GAIN_LSB       4
`define AEPO_SLEEP_BIT      15

// Reset values and wake threshold floor
`define AEPO_WLSB_RST       7'h04
`define AEPO_WLSB_MIN       7'h04
`define AEPO_GAIN_RST       3'h0

// Timing
`define AEPO_CLK_NS         8
`define AEPO_TO_MIN_NS      20000
`define AEPO_TO_MAX_NS      24000
`define AEPO_PWM_UNIT_PS    556
`define AEPO_PWM_PERIOD     257

`endif

/* hw/aepo_pwm.v */
// Pulse width output generator for the angle position
`timescale 1ns/10ps
`include "aepo_regs.vh"

module aepo_pwm #(
  parameter UNIT_CYC = 69
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // Angle source
  input  wire [7:0] angle,
  input  wire       angle_valid,
  // Pulse output
  output reg        pwm_out_ff
);

  reg  [15:0] unit_cnt_ff;   // Cycles within one time unit
  reg  [8:0]  slot_cnt_ff;   // Time unit within the period, 0..256
  reg  [7:0]  angle_lat_ff;  // Angle frozen for the whole period
  wire        unit_end;
  wire [8:0]  slot_nxt;

  assign unit_end = (unit_cnt_ff == UNIT_CYC[15:0] - 16'h0001);
  assign slot_nxt = (slot_cnt_ff == 9'h100) ? 9'h000 : slot_cnt_ff + 9'h001;

  // Unit and period counters; angle latched at period start to avoid glitchy widths
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      unit_cnt_ff  <= 16'h0000;
      slot_cnt_ff  <= 9'h000;
      angle_lat_ff <= 8'h00;
      pwm_out_ff   <= 1'b0;
    end else begin
      unit_cnt_ff <= unit_end ? 16'h0000 : unit_cnt_ff + 16'h0001;
      if (unit_end) begin
        slot_cnt_ff <= slot_nxt; // Period of 257 units
        if (slot_nxt == 9'h000)
          angle_lat_ff <= angle;
      end
      // High for angle+1 units, low for 256-angle units
      if (!angle_valid)
        pwm_out_ff <= 1'b0; // Invalid data holds low
      else
        pwm_out_ff <= (slot_cnt_ff <= {1'b0, angle_lat_ff});
    end
  end

endmodule // aepo_pwm

/* hw/aepo_serial.v */
// Three-wire serial command port with gain mirror and pulse output
`timescale 1ns/10ps
`include "aepo_regs.vh"

// Notes on behaviour
// - Select, clock and one shared data line
// - All command and data bits use data line
// - Five command bits then sixteen data bits
// - Command bits sampled on rising clock edges
// - Drive read data half period after command
// - Select removed releases the data line
// - Abandon transfer after idle timeout, in two-wire mode only
// - Extended mode uses identical framing
// - Pulse high for angle plus one units
// - Pulse period totals 257 units
// - One unit is nominally 0.556 us
// - Invalid angle holds pulse output low
// - No low power when pulse output used
// - Gain is three bits, eight steps
// - Gain from memory or mirror register
// - Command zero returns angle, agc, lock, parity
// - Custom read returns threshold and gain
module aepo_serial #(
  parameter TO_CYC   = 2500,
  parameter UNIT_CYC = 69
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // Serial link pins
  input  wire       sel_n_in,
  input  wire       link_clk_in,
  input  wire       bidir_data_line_in,
  output reg        bidir_data_line_out_ff,
  output reg        bidir_data_line_oe_ff,
  // Measurement inputs
  input  wire [7:0] angle,
  input  wire [5:0] agc_level,
  input  wire       adc_lock,
  input  wire       angle_valid,
  input  wire [7:0] turn_count,
  // Configuration
  input  wire       two_wire_mode,
  input  wire       pwm_is_output,
  input  wire [2:0] otp_gain,
  input  wire       otp_gain_sel,
  input  wire       ext_mode,
  // Results
  output reg  [2:0] gain_ff,
  output reg        low_power_ff,
  output reg  [6:0] wake_lsb_ff,
  output reg        xt_write_ff,
  output reg  [20:0] xt_word_ff,
  output wire       pwm_out
);

  // Frame sequencer states; ST_IDLE also covers the cycle after a timeout
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD  = 2'h1;
  localparam ST_DATA = 2'h2;

  // Pin synchronisers, first stage read only by second
  reg  [1:0]  sel_sync_ff;
  reg  [1:0]  clk_sync_ff;
  reg  [1:0]  dat_sync_ff;
  reg         clk_prev_ff;     // Previous synchronised clock level
  reg  [1:0]  state_ff;
  reg  [4:0]  bit_cnt_ff;      // Rising edges seen in this frame
  reg  [4:0]  cmd_ff;          // Shifted command
  reg  [15:0] shift_ff;        // Write data in or read data out
  reg  [15:0] to_cnt_ff;       // Idle cycles since last rising edge
  reg         drv_pend_ff;     // Waiting for half period to drive
  reg  [15:0] half_cnt_ff;     // Measured half period of link clock
  reg         sleep_req_ff;    // Requested low power mode
  reg  [2:0]  mirror_gain_ff;  // Gain mirror written over the port
  wire        sel_act;
  wire        clk_rise;
  wire        clk_fall;
  wire        dat_bit;
  wire [4:0]  cmd_full;
  reg  [15:0] rd_word;

  // Select is active low at the pin; edges are found on the synchronised clock level,
  // so every pin change is seen two system clocks late
  assign sel_act  = ~sel_sync_ff[1];
  assign clk_rise = clk_sync_ff[1] & ~clk_prev_ff;
  assign clk_fall = ~clk_sync_ff[1] & clk_prev_ff;
  assign dat_bit  = dat_sync_ff[1];
  assign cmd_full = {cmd_ff[3:0], dat_bit};

  // Even parity over the upper fifteen bits
  function [15:0] with_parity;
    input [14:0] v;
    begin
      with_parity = {v, ^v};
    end
  endfunction

  // Read word for the completed command
  // Unknown read codes give zero rather than a stale word
  always @* begin
    rd_word = 16'h0000;
    case (cmd_full)
      `AEPO_CMD_RD_ANGLE:
        rd_word = with_parity({adc_lock & ~low_power_ff, agc_level, angle});
      `AEPO_CMD_RD_MULTI:
        rd_word = with_parity({adc_lock & ~low_power_ff, agc_level, turn_count});
      `AEPO_CMD_RD_BOTH:
        rd_word = {turn_count, angle};
      `AEPO_CMD_RD_CUSTOM:
        rd_word = with_parity({2'h0, wake_lsb_ff, mirror_gain_ff, 3'h0});
      default:
        rd_word = 16'h0000;
    endcase
  end

  // Two-flop synchronisers on every pin input
  // Reset levels match the idle pins, so no false edge follows reset
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sel_sync_ff <= 2'h3;
      clk_sync_ff <= 2'h0;
      dat_sync_ff <= 2'h0;
      clk_prev_ff <= 1'b0;
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], sel_n_in};
      clk_sync_ff <= {clk_sync_ff[0], link_clk_in};
      dat_sync_ff <= {dat_sync_ff[0], bidir_data_line_in};
      clk_prev_ff <= clk_sync_ff[1];
    end
  end

  // Half period of link clock, measured from rising to falling edge
  // The idle count restarts at each rising edge, so at the falling edge it holds the
  // high time; a controller with an uneven duty cycle moves the drive point with it
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      half_cnt_ff <= 16'h0001;
    else if (clk_fall && to_cnt_ff != 16'h0000)
      half_cnt_ff <= to_cnt_ff;
  end

  // Frame sequencer
  // The edge detector needs the link clock well below a quarter of the system clock;
  // faster links would lose edges rather than shift garbage
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff               <= ST_IDLE;
      bit_cnt_ff             <= 5'h00;
      cmd_ff                 <= 5'h00;
      shift_ff               <= 16'h0000;
      to_cnt_ff              <= 16'h0000;
      drv_pend_ff            <= 1'b0;
      bidir_data_line_out_ff <= 1'b0;
      bidir_data_line_oe_ff  <= 1'b0;
      wake_lsb_ff            <= `AEPO_WLSB_RST;
      mirror_gain_ff         <= `AEPO_GAIN_RST;
      sleep_req_ff           <= 1'b0;
      xt_write_ff            <= 1'b0;
      xt_word_ff             <= 21'h000000;
    end else begin
      xt_write_ff <= 1'b0;
      if (!sel_act) begin
        // Select removed: float line, restart count
        state_ff              <= ST_IDLE;
        bit_cnt_ff            <= 5'h00;
        drv_pend_ff           <= 1'b0;
        bidir_data_line_oe_ff <= 1'b0;
        to_cnt_ff             <= 16'h0000;
      end else if (two_wire_mode && state_ff != ST_IDLE && !clk_rise &&
                   to_cnt_ff >= TO_CYC[15:0]) begin
        // Idle too long after a rising edge: drop frame
        // An edge in this very cycle is activity and is taken below instead
        state_ff              <= ST_IDLE;
        bit_cnt_ff            <= 5'h00;
        drv_pend_ff           <= 1'b0;
        bidir_data_line_oe_ff <= 1'b0;
        // Restart the idle count so that the next frame is not dropped at once
        to_cnt_ff             <= 16'h0000;
      end else begin
        if (state_ff == ST_IDLE)
          state_ff <= ST_CMD;
        to_cnt_ff <= clk_rise ? 16'h0000 :
                     (to_cnt_ff == 16'hFFFF ? to_cnt_ff : to_cnt_ff + 16'h0001);
        // The line was released at the last command edge; driving only after the
        // measured half period keeps clear of the controller's hold time
        // Drive read data half period after last command edge
        if (drv_pend_ff && to_cnt_ff >= half_cnt_ff) begin
          drv_pend_ff            <= 1'b0;
          bidir_data_line_oe_ff  <= 1'b1;
          bidir_data_line_out_ff <= shift_ff[15];
        end
        // Next data bit placed at falling edge, stable over rising
        if (clk_fall && bidir_data_line_oe_ff && bit_cnt_ff > 5'h05) begin
          bidir_data_line_out_ff <= shift_ff[15];
        end
        // Select is active here, so an edge just after select or a timeout counts
        if (clk_rise) begin
          // Saturates, so stray edges past the frame never wrap into a new command
          bit_cnt_ff <= (bit_cnt_ff == 5'h1F) ? bit_cnt_ff : bit_cnt_ff + 5'h01;
          if (bit_cnt_ff < `AEPO_CMD_BITS - 1) begin
            cmd_ff <= cmd_full; // Command MSB first
          end else if (bit_cnt_ff == `AEPO_CMD_BITS - 1) begin
            cmd_ff   <= cmd_full;
            state_ff <= ST_DATA;
            if (!cmd_full[4]) begin
              // Read: release now, drive later
              shift_ff              <= rd_word;
              bidir_data_line_oe_ff <= 1'b0;
              drv_pend_ff           <= 1'b1;
            end
          end else if (bit_cnt_ff < `AEPO_FRAME_BITS) begin
            if (!cmd_ff[4]) begin
              shift_ff <= {shift_ff[14:0], 1'b0}; // D15 first
            end else begin
              shift_ff <= {shift_ff[14:0], dat_bit};
            end
            if (bit_cnt_ff == `AEPO_FRAME_BITS - 1 && cmd_ff[4]) begin
              // Write completes on the last rising edge
              if (ext_mode || cmd_ff >= `AEPO_CMD_XT_FIRST) begin
                xt_write_ff <= 1'b1; // Same framing in extended mode
                xt_word_ff  <= {cmd_ff, shift_ff[14:0], dat_bit};
              end else if (cmd_ff == `AEPO_CMD_WR_CUSTOM) begin
                // Thresholds below the floor are raised to the floor
                wake_lsb_ff <= (shift_ff[12:6] < `AEPO_WLSB_MIN) ?
                               `AEPO_WLSB_MIN : shift_ff[12:6];
                mirror_gain_ff <= shift_ff[5:3];
              end else if (cmd_ff == `AEPO_CMD_WR_CONFIG) begin
                sleep_req_ff <= shift_ff[14];
              end
            end
          end
        end
      end
    end
  end

  // Gain source and low power gating
  // A sleep request is kept while the pulse output is in use and takes effect
  // only once the pulse output is released
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gain_ff      <= `AEPO_GAIN_RST;
      low_power_ff <= 1'b0;
    end else begin
      gain_ff      <= otp_gain_sel ? otp_gain : mirror_gain_ff;
      low_power_ff <= sleep_req_ff & ~pwm_is_output;
    end
  end

  // Pulse width angle output
  // Runs free of the serial port; the angle is taken once per period
  aepo_pwm #(
    .UNIT_CYC (UNIT_CYC)
  ) u_pwm (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .angle       (angle),
    .angle_valid (angle_valid),
    .pwm_out_ff  (pwm_out)
  );

endmodule // aepo_serial

/* tb/aepo_serial_checker.sv */
// Port-level assertions for the serial port block
`timescale 1ns/10ps
module aepo_serial_checker #(parameter TO_CYC = 2500, parameter UNIT_CYC = 69) (
  // Clock and reset
  input wire       clk_sys, resetn,
  // Link, gain and power
  input wire       sel_n_in, bidir_data_line_oe_ff, otp_gain_sel, pwm_is_output, low_power_ff,
  input wire [2:0] otp_gain, gain_ff,
  input wire [6:0] wake_lsb_ff,
  // Strobe and pulse output
  input wire       xt_write_ff, angle_valid, pwm_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Select high long enough to clear the synchroniser
  sequence s_sel_idle;
    sel_n_in [*6];
  endsequence
  // Memory gain chosen and steady, allowing two clocks of latency
  sequence s_gain_held;
    otp_gain_sel [*3] ##0 ($stable(otp_gain) && $past(otp_gain) == $past(otp_gain, 2));
  endsequence
  a_sel_release: assert property (s_sel_idle |-> !bidir_data_line_oe_ff)
    else $error("line driven while deselected");
  a_cmd_quiet: assert property ($fell(sel_n_in) |=> !bidir_data_line_oe_ff [*8])
    else $error("line driven in command phase");
  a_drive_frame: assert property ($rose(bidir_data_line_oe_ff) |-> !$past(sel_n_in, 4))
    else $error("line driven outside a frame");
  a_gain_memory: assert property (s_gain_held |-> gain_ff == otp_gain)
    else $error("gain ignores memory");
  a_power_block: assert property (pwm_is_output [*4] |-> !low_power_ff)
    else $error("low power with pulse output");
  a_pulse_low: assert property (!angle_valid [*4] |-> !pwm_out)
    else $error("pulse with invalid angle");
  a_wake_floor: assert property (wake_lsb_ff >= 7'h04)
    else $error("wake threshold below floor");
  a_xt_single: assert property (xt_write_ff |=> !xt_write_ff)
    else $error("extended strobe too long");
endmodule // aepo_serial_checker

bind aepo_serial aepo_serial_checker #(.TO_CYC(TO_CYC), .UNIT_CYC(UNIT_CYC)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .sel_n_in(sel_n_in),
  .bidir_data_line_oe_ff(bidir_data_line_oe_ff), .otp_gain_sel(otp_gain_sel),
  .pwm_is_output(pwm_is_output), .low_power_ff(low_power_ff), .otp_gain(otp_gain),
  .gain_ff(gain_ff), .wake_lsb_ff(wake_lsb_ff), .xt_write_ff(xt_write_ff),
  .angle_valid(angle_valid), .pwm_out(pwm_out));

/* tb/aepo_ctl_model.sv */
// Serial controller model for the three-wire link
`timescale 1ns/10ps
module aepo_ctl_model (
  // Link pins; the clock idles low between frames
  output reg  sel_n,
  output reg  link_clk,
  output reg  m_out,
  output reg  m_oe,
  input  wire bidir_data_line
);
  initial {sel_n, link_clk, m_out, m_oe} = 4'b1000;
  // Clock n bits of {cmd, data}; a read hands the line over after the command
  task automatic bits(input [20:0] w, input integer n, output [15:0] rd);
    integer i;
    begin
      rd = 16'h0000;
      sel_n = 1'b0;
      m_oe = 1'b1;
      for (i = 0; i < n; i++) begin
        m_out = w[20-i]; // Command then data, MSB first
        #62.5 link_clk = 1'b1; // Device samples here
        if (i > 4) rd = {rd[14:0], bidir_data_line};
        #30 m_oe = m_oe && (w[20] || i != 4); // Release only after hold time
        #32.5 link_clk = 1'b0;
      end
    end
  endtask
  // Whole frame; select stays low past the last edge
  task automatic xfer(input [4:0] c, input [15:0] d, output [15:0] rd);
    begin
      bits({c, d}, 21, rd);
      #40 sel_n = 1'b1;
      m_oe = 1'b0;
      #100;
    end
  endtask
endmodule // aepo_ctl_model

/* tb/tb_aepo_serial.sv */
// Self-checking bench for the serial port and pulse output
`timescale 1ns/10ps
`include "aepo_regs.vh"
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected %0t %s", $time, m); end end
module tb_aepo_serial;
  // Stimulus and observed levels
  reg         clk_sys = 0, resetn = 0, fl_ff = 0;
  reg  [7:0]  angle;
  reg  [5:0]  agc;
  reg  [2:0]  og;
  reg         lock, valid, two_w, pwm_sel, og_sel, ext;
  wire        sel_n, lclk, m_out, m_oe, d_out, d_oe, lp, xw, pwm;
  wire [2:0]  gain;
  wire [6:0]  wl;
  wire [20:0] xword;
  reg  [20:0] xt_seen;
  reg  [15:0] rd;
  integer     n_tests = 0, mismatches = 0, i, j, hi, lo;
  // An undriven line wanders rather than keeping its last value
  wire        bidir_data_line = d_oe ? d_out : m_oe ? m_out : fl_ff;
  aepo_serial #(.TO_CYC(50), .UNIT_CYC(4)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .sel_n_in(sel_n), .link_clk_in(lclk), .bidir_data_line_in(bidir_data_line),
    .bidir_data_line_out_ff(d_out), .bidir_data_line_oe_ff(d_oe), .angle(angle),
    .agc_level(agc), .adc_lock(lock), .angle_valid(valid), .turn_count(8'h3C),
    .two_wire_mode(two_w), .pwm_is_output(pwm_sel), .otp_gain(og), .otp_gain_sel(og_sel),
    .ext_mode(ext), .gain_ff(gain), .low_power_ff(lp), .wake_lsb_ff(wl),
    .xt_write_ff(xw), .xt_word_ff(xword), .pwm_out(pwm));
  aepo_ctl_model m (.sel_n(sel_n), .link_clk(lclk), .m_out(m_out), .m_oe(m_oe), .bidir_data_line(bidir_data_line));
  always #4 clk_sys = ~clk_sys;
  // Float pattern, strobe capture and contention watch
  always @(posedge clk_sys) begin
    fl_ff <= ~fl_ff;
    if (xw === 1'b1) xt_seen <= xword;
    if (d_oe === 1'b1 && m_oe) `CHK(1'b1, 1'b0, "contention")
  end
  task test_done;
    begin
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Angle word: lock, agc, angle, even parity gives 16'hD74B
  task t_read;
    begin
      @(posedge clk_sys) {angle, agc, lock} <= {8'hA5, 6'h2B, 1'b1};
      m.xfer(`AEPO_CMD_RD_ANGLE, 16'h0000, rd);
      `CHK(rd, 16'hD74B, "angle word")
      m.xfer(`AEPO_CMD_RD_MULTI, 16'h0000, rd);
      `CHK(rd, 16'hD679, "multiturn word")
      m.xfer(`AEPO_CMD_RD_BOTH, 16'h0000, rd);
      `CHK(rd, 16'h3CA5, "both word")
      m.xfer(5'h05, 16'h0000, rd);
      `CHK(rd, 16'h0000, "unknown word")
      `CHK(d_oe, 1'b0, "line held")
      $display("end read");
    end
  endtask
  // Mirror write and read back, then every memory gain code
  task t_gain;
    begin
      m.xfer(`AEPO_CMD_WR_CUSTOM, 16'h2AE0, rd);
      m.xfer(`AEPO_CMD_RD_CUSTOM, 16'h0000, rd);
      `CHK(rd, 16'h2AE0, "custom word")
      `CHK(gain, 3'h6, "mirror gain")
      for (i = 0; i < 8; i++) begin
        @(posedge clk_sys) {og, og_sel} <= {i[2:0], 1'b1};
        repeat (2) @(posedge clk_sys);
        #1 `CHK(gain, i[2:0], "memory gain")
      end
      @(posedge clk_sys) og_sel <= 1'b0;
      $display("end gain");
    end
  endtask
  task t_sleep;
    begin
      m.xfer(`AEPO_CMD_WR_CONFIG, 16'h8000, rd);
      `CHK(lp, 1'b1, "sleep")
      @(posedge clk_sys) pwm_sel <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1 `CHK(lp, 1'b0, "sleep with pulse")
      $display("end sleep");
    end
  endtask
  task t_xt;
    begin
      @(posedge clk_sys) ext <= 1'b1; // Programming supply present
      m.xfer(`AEPO_CMD_XT_FIRST, 16'h1234, rd);
      `CHK(xt_seen, {`AEPO_CMD_XT_FIRST, 16'h1234}, "extended word")
      m.xfer(`AEPO_CMD_WR_CUSTOM, 16'h0300, rd);
      `CHK(xt_seen, {`AEPO_CMD_WR_CUSTOM, 16'h0300}, "extended custom")
      `CHK(wl, 7'h55, "mirror untouched")
      @(posedge clk_sys) ext <= 1'b0;
      $display("end xt");
    end
  endtask
  // Stray edges, silence, then a full frame under the same select
  task t_timeout;
    begin
      @(posedge clk_sys) two_w <= 1'b1;
      m.bits(21'h1FFFFF, 3, rd);
      repeat (80) @(posedge clk_sys);
      m.xfer(`AEPO_CMD_WR_CUSTOM, 16'h0520, rd);
      `CHK(wl, 7'h0A, "frame after timeout")
      $display("end timeout");
    end
  endtask
  // Time one high and one low phase at falling edges, where levels are settled
  task meas;
    begin
      hi = 0;
      lo = 0;
      for (i = 0; i < 3000 && pwm !== 1'b1; i++) @(negedge clk_sys);
      for (i = 0; i < 3000 && pwm === 1'b1; i++) @(negedge clk_sys) hi++;
      for (i = 0; i < 3000 && pwm !== 1'b1; i++) @(negedge clk_sys) lo++;
      if (i == 3000) begin mismatches++; test_done; end
    end
  endtask
  // Angles 00, 0F and FF; the first period after a change is thrown away
  task t_pwm;
    begin
      for (j = 0; j < 3; j++) begin
        @(posedge clk_sys) {angle, valid} <= {8'hFF >> (8 - 4 * j), 1'b1};
        meas;
        meas;
        `CHK(hi, (angle + 1) * 4, "high time")
        `CHK(hi + lo, 257 * 4, "period")
      end
      @(posedge clk_sys) valid <= 1'b0;
      repeat (10) @(posedge clk_sys);
      hi = 0;
      for (i = 0; i < 1100; i++) @(negedge clk_sys) hi = hi + (pwm !== 1'b0);
      `CHK(hi, 0, "pulse while invalid")
      $display("end pwm");
    end
  endtask
  initial begin
    {angle, agc, og, lock, valid, two_w, pwm_sel, og_sel, ext} = 0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    `CHK(wl, `AEPO_WLSB_RST, "wake threshold reset")
    t_read;
    t_gain;
    t_sleep;
    t_xt;
    t_timeout;
    t_pwm;
    test_done;
  end
endmodule // tb_aepo_serial
